/* dv/seiu_event_unit_asserts.sv */
module seiu_event_unit_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] fifo_fill,
  input wire logic meas_start,
  input wire logic meas_busy,
  input wire logic pad_out,
  input wire logic pad_oe_n
);
  localparam int CONV_MIN = seiu_pkg::CONV_BASE_US * seiu_pkg::TICK_CYCLES - 2;
  logic [7:0] ctrl;
  logic [12:0] busy_cnt;
  logic mapped;
  assign mapped = reg_addr inside {seiu_pkg::EVT_STATUS_ADDR, seiu_pkg::WTM_LOW_ADDR, seiu_pkg::WTM_HIGH_ADDR,
                                   seiu_pkg::EVT_CTRL_ADDR};
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl <= seiu_pkg::CTRL_RESET;
      busy_cnt <= 13'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == seiu_pkg::EVT_CTRL_ADDR)
        ctrl <= reg_wdata;
      busy_cnt <= meas_busy ? busy_cnt + 13'h1 : 13'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (reg_rd && reg_addr == seiu_pkg::EVT_CTRL_ADDR |=>
    (reg_rdata & 8'h5f) == ($past(ctrl) & 8'h5f)) else $error("control readback wrong");
  a_pushpull_drive: assert property ($stable(ctrl) && !ctrl[0] |-> !pad_oe_n)
    else $error("push-pull pad not driven");
  a_od_low_only: assert property ($stable(ctrl) && ctrl[0] |-> pad_oe_n || !pad_out)
    else $error("open-drain pad driven high");
  a_unmapped_idle: assert property (ctrl == $past(ctrl) && ctrl == $past(ctrl, 2) && !ctrl[0]
    && (ctrl & 8'h58) == 8'h00 |-> pad_out == !ctrl[1]) else $error("pad asserted with no mapping");
  a_full_live: assert property (ctrl == $past(ctrl) && ctrl == $past(ctrl, 2) && (ctrl & 8'h15) == 8'h10
    && fifo_fill >= seiu_pkg::FIFO_FULL_LEVEL && $past(fifo_fill) >= seiu_pkg::FIFO_FULL_LEVEL
    && $past(fifo_fill, 2) >= seiu_pkg::FIFO_FULL_LEVEL |-> pad_out == ctrl[1]) else $error("full pad missing");
  a_start_busy: assert property (meas_start && !meas_busy |=> meas_busy)
    else $error("start did not raise busy");
  a_conv_floor: assert property ($fell(meas_busy) |-> busy_cnt >= CONV_MIN)
    else $error("conversion shorter than base time");
  c_conv_done: cover property ($fell(meas_busy));
  c_status_read: cover property (reg_rd && reg_addr == seiu_pkg::EVT_STATUS_ADDR);
  c_pad_release: cover property (pad_oe_n);
endmodule // seiu_event_unit_asserts

bind seiu_event_unit seiu_event_unit_asserts u_seiu_event_unit_asserts (.core_clk, .sys_rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .fifo_fill, .meas_start, .meas_busy, .pad_out, .pad_oe_n);

/* dv/seiu_event_unit_tb.sv */
module seiu_event_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, xfer_end, meas_start, meas_busy, pad_out, pad_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [9:0] fifo_fill = 10'h000;
  logic [4:0] odr_sel;
  logic [23:0] press_data, temp_data;
  logic [23:0] press_raw = 24'habcdef;
  logic [23:0] temp_raw = 24'h123456;
  wire logic pad_w;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  // The pad carries a pull-up, so a released open-drain pad reads high.
  assign pad_w = pad_oe_n ? 1'b1 : pad_out;
  always #25 core_clk = ~core_clk;
  seiu_host_model u_seiu_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .xfer_end(xfer_end));
  seiu_event_unit u_seiu_event_unit (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .xfer_end(xfer_end), .reg_rdata(reg_rdata), .fifo_fill(fifo_fill),
    .meas_start(meas_start), .press_en(1'b0), .temp_en(1'b0), .osr_p(3'h0), .osr_t(3'h0),
    .press_raw(press_raw), .temp_raw(temp_raw), .meas_busy(meas_busy), .odr_sel(odr_sel),
    .press_data(press_data), .temp_data(temp_data), .pad_in(pad_w), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdv(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    u_seiu_host_model.rd(a, d);
    chk({16'h0, d & m}, {16'h0, exp});
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    u_seiu_host_model.wr(a, d);
    u_seiu_host_model.xend();
  endtask
  task automatic setfill(input logic [9:0] f);
    fifo_fill = f;
    repeat (3) @(negedge core_clk);
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic conv();
    @(negedge core_clk);
    meas_start = 1'b1;
    @(negedge core_clk);
    meas_start = 1'b0;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (meas_busy && n < 6000);
    repeat (3) @(negedge core_clk);
  endtask
  initial
  begin
    meas_start = 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(pad_oe_n, 1'b0);
    rdv(seiu_pkg::EVT_CTRL_ADDR, 8'hff, 8'h02);
    rdv(8'h42, 8'hff, 8'h00);
    $display("test reset done");
    u_seiu_host_model.wr(seiu_pkg::WTM_LOW_ADDR, 8'h10);
    wr1(seiu_pkg::WTM_HIGH_ADDR, 8'h00);
    setfill(10'h010);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h01, 8'h01);
    setfill(10'h00f);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h01, 8'h00);
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h0a);
    setfill(10'h010);
    chk(pad_w, 1'b1);
    u_seiu_host_model.wr(seiu_pkg::WTM_LOW_ADDR, 8'h00);
    wr1(seiu_pkg::WTM_HIGH_ADDR, 8'h00);
    repeat (3) @(negedge core_clk);
    chk(pad_w, 1'b0);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h01, 8'h00);
    $display("test watermark done");
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h16);
    setfill(10'h1f8);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h02, 8'h02);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h02, 8'h02);
    setfill(10'h1f4);
    chk(pad_w, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h14 | 8'(k));
      repeat (3) @(negedge core_clk);
      chk(pad_w, k[1]);
    end
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h16);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h02, 8'h02);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h02, 8'h00);
    repeat (3) @(negedge core_clk);
    chk(pad_w, 1'b0);
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h12);
    setfill(10'h1f8);
    chk(pad_w, 1'b1);
    setfill(10'h1f7);
    chk(pad_w, 1'b0);
    setfill(10'h000);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'hff, 8'h00);
    $display("test full and pad done");
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h46);
    conv();
    chk(n >= 4680 && n <= 4700, 1'b1);
    chk(press_data, 24'habcdef);
    chk(temp_data, 24'h123456);
    chk(odr_sel, 5'h00);
    chk(pad_w, 1'b1);
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h42);
    repeat (3) @(negedge core_clk);
    chk(pad_w, 1'b1);
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h46);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h08, 8'h08);
    rdv(seiu_pkg::EVT_STATUS_ADDR, 8'h08, 8'h00);
    chk(pad_w, 1'b0);
    wr1(seiu_pkg::EVT_CTRL_ADDR, 8'h42);
    press_raw = 24'h654321;
    temp_raw = 24'hfedcba;
    conv();
    chk(press_data, 24'h654321);
    chk(temp_data, 24'hfedcba);
    chk(pad_w, 1'b1);
    repeat (48000) @(negedge core_clk);
    chk(pad_w, 1'b1);
    repeat (4000) @(negedge core_clk);
    chk(pad_w, 1'b0);
    $display("test data ready done");
    finish_test();
  end
endmodule // seiu_event_unit_tb

/* dv/seiu_host_model.sv */
module seiu_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic xfer_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    xfer_end = 1'b0;
  end
  // Writes inside one transaction hold the strobe high back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
  endtask
  // Released bus lines show inverted values so stale data cannot pass.
  task automatic xend();
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    xfer_end = 1'b1;
    @(negedge core_clk);
    xfer_end = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    xfer_end = 1'b1;
    @(negedge core_clk);
    xfer_end = 1'b0;
  endtask
endmodule // seiu_host_model

/* rtl/seiu_conv_timer.sv */
// Paces measurements: runs one conversion per start and reports the
// output-rate exponent that the conversion length allows.
module seiu_conv_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic us_tick,
  input wire logic start,
  input wire logic press_en,
  input wire logic temp_en,
  input wire logic [2:0] osr_p,
  input wire logic [2:0] osr_t,
  output logic busy,
  output logic done,
  output logic [4:0] odr_sel
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [seiu_pkg::US_W-1:0] count;
    logic [seiu_pkg::US_W-1:0] length;
    logic [4:0] odr_sel;
  } seiu_ct_state_t;

  seiu_ct_state_t state;
  seiu_ct_state_t next_state;
  logic [seiu_pkg::US_W-1:0] conv_us;
  logic [4:0] sel;

  always_comb
  begin
    conv_us = seiu_pkg::US_W'(seiu_pkg::CONV_BASE_US);
    if (press_en)
    begin
      conv_us = conv_us + seiu_pkg::US_W'(seiu_pkg::CONV_PRESS_US)
        + (seiu_pkg::US_W'(seiu_pkg::CONV_OSR_US) << osr_p);
    end
    if (temp_en)
    begin
      conv_us = conv_us + seiu_pkg::US_W'(seiu_pkg::CONV_TEMP_US)
        + (seiu_pkg::US_W'(seiu_pkg::CONV_OSR_US) << osr_t);
    end
    // Smallest exponent whose period covers the conversion (ceiling of log2).
    sel = 5'h00;
    for (int i = 17; i >= 0; i--)
    begin
      if ((seiu_pkg::US_W'(seiu_pkg::ODR_BASE_US) << i) >= conv_us)
      begin
        sel = 5'(i);
      end
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.done = 1'b0;
    next_state.odr_sel = sel;
    if (start && !state.busy)
    begin
      next_state.busy = 1'b1;
      next_state.count = '0;
      next_state.length = conv_us;
    end
    else if (state.busy && us_tick)
    begin
      if (state.count + 1'b1 >= state.length)
      begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
  assign done = state.done;
  assign odr_sel = state.odr_sel;
endmodule // seiu_conv_timer

/* rtl/seiu_event_unit.sv */
module seiu_event_unit (
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port from the serial interface logic, same clock.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic xfer_end,
  output logic [7:0] reg_rdata,
  // FIFO fill level, same clock.
  input wire logic [9:0] fifo_fill,
  // Measurement control.
  input wire logic meas_start,
  input wire logic press_en,
  input wire logic temp_en,
  input wire logic [2:0] osr_p,
  input wire logic [2:0] osr_t,
  input wire logic [23:0] press_raw,
  input wire logic [23:0] temp_raw,
  output logic meas_busy,
  output logic [4:0] odr_sel,
  output logic [23:0] press_data,
  output logic [23:0] temp_data,
  // Event pad, split into its three signals.
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n
);
  localparam int TICK_LOCAL = seiu_pkg::TICK_W;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] wtm_low;
    logic [7:0] wtm_high;
    logic [8:0] wtm_level;
    logic wtm_cond;
    logic wtm_dirty;
    logic fwtm_flag;
    logic ffull_flag;
    logic drdy_flag;
    logic drdy_live;
    logic [11:0] drdy_us;
    logic [TICK_LOCAL-1:0] tick_cnt;
    logic us_tick;
    logic [23:0] press_data;
    logic [23:0] temp_data;
    logic [7:0] rdata;
    logic pad_out;
    logic pad_oe_n;
  } seiu_state_t;

  seiu_state_t state;
  seiu_state_t next_state;
  logic conv_done;
  logic wtm_hit;
  logic latch;
  logic fwtm_src;
  logic ffull_src;
  logic drdy_src;
  logic pad_active;
  logic [7:0] status_byte;
  logic pad_sync0;
  logic pad_sync1;

  seiu_conv_timer u_conv (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .us_tick(state.us_tick),
    .start(meas_start),
    .press_en(press_en),
    .temp_en(temp_en),
    .osr_p(osr_p),
    .osr_t(osr_t),
    .busy(meas_busy),
    .done(conv_done),
    .odr_sel(odr_sel)
  );

  // The pad level is sampled back only for board-level checks; it is synchronised.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pad_sync0 <= 1'b0;
      pad_sync1 <= 1'b0;
    end
    else
    begin
      pad_sync0 <= pad_in;
      pad_sync1 <= pad_sync0;
    end
  end

  always_comb
  begin
    latch = state.ctrl[seiu_pkg::CTRL_LATCH];
    wtm_hit = (state.wtm_level != 9'h000) && ({1'b0, fifo_fill} >= {2'b00, state.wtm_level});
    status_byte = 8'h00;
    status_byte[seiu_pkg::STAT_FWTM] = state.fwtm_flag;
    status_byte[seiu_pkg::STAT_FFULL] = state.ffull_flag;
    status_byte[seiu_pkg::STAT_DRDY] = state.drdy_flag;
    // Stored flag in latched mode, live condition otherwise.
    fwtm_src = latch ? state.fwtm_flag : state.wtm_cond;
    ffull_src = latch ? state.ffull_flag : (fifo_fill >= seiu_pkg::FIFO_FULL_LEVEL);
    // The self-clear timer drops the live event itself, so an event left over from latched mode stays up.
    drdy_src = state.drdy_live;
    pad_active = (state.ctrl[seiu_pkg::CTRL_FWTM_EN] && fwtm_src)
      || (state.ctrl[seiu_pkg::CTRL_FFULL_EN] && ffull_src)
      || (state.ctrl[seiu_pkg::CTRL_DRDY_EN] && drdy_src);
  end

  always_comb
  begin
    next_state = state;
    // Microsecond tick from the 50 ns clock.
    next_state.us_tick = 1'b0;
    if (state.tick_cnt == TICK_LOCAL'(seiu_pkg::TICK_CYCLES - 1))
    begin
      next_state.tick_cnt = '0;
      next_state.us_tick = 1'b1;
    end
    else
    begin
      next_state.tick_cnt = state.tick_cnt + 1'b1;
    end
    // Restarting the tick with each conversion makes its length exact. A running self-clear
    // interval may run up to one microsecond longer when a conversion starts under it.
    if (meas_start && !meas_busy)
    begin
      next_state.tick_cnt = '0;
      next_state.us_tick = 1'b0;
    end

    // Register writes.
    if (reg_wr)
    begin
      case (reg_addr)
        seiu_pkg::WTM_LOW_ADDR:
        begin
          next_state.wtm_low = reg_wdata;
          next_state.wtm_dirty = 1'b1;
        end
        seiu_pkg::WTM_HIGH_ADDR:
        begin
          next_state.wtm_high = reg_wdata;
          next_state.wtm_dirty = 1'b1;
        end
        seiu_pkg::EVT_CTRL_ADDR:
        begin
          next_state.ctrl = reg_wdata;
          // A late mapping of data-ready must not show the old event.
          if (reg_wdata[seiu_pkg::CTRL_DRDY_EN] && !state.ctrl[seiu_pkg::CTRL_DRDY_EN])
          begin
            next_state.drdy_live = 1'b0;
          end
          // Leaving latched mode leaves the old event without a timer.
          if (!reg_wdata[seiu_pkg::CTRL_LATCH] && state.ctrl[seiu_pkg::CTRL_LATCH])
          begin
            next_state.drdy_us = 12'h000;
          end
        end
        default:
        begin
        end
      endcase
    end

    // The level is only taken once the whole transaction has ended, from the bytes stored before
    // that cycle; a watermark write in the xfer_end cycle itself is left out, and wtm_dirty is cleared.
    if (xfer_end && (state.wtm_dirty || (reg_wr && (reg_addr == seiu_pkg::WTM_LOW_ADDR
      || reg_addr == seiu_pkg::WTM_HIGH_ADDR))))
    begin
      next_state.wtm_level = {state.wtm_high[0], state.wtm_low};
      next_state.wtm_dirty = 1'b0;
    end
    next_state.wtm_cond = wtm_hit;

    // Read data and read-to-clear.
    next_state.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        seiu_pkg::WTM_LOW_ADDR: next_state.rdata = state.wtm_low;
        seiu_pkg::WTM_HIGH_ADDR: next_state.rdata = state.wtm_high;
        seiu_pkg::EVT_CTRL_ADDR: next_state.rdata = state.ctrl;
        seiu_pkg::EVT_STATUS_ADDR:
        begin
          next_state.rdata = status_byte;
          if (state.fwtm_flag)
          begin
            next_state.fwtm_flag = 1'b0;
          end
          if (state.ffull_flag && fifo_fill < seiu_pkg::FIFO_FULL_LEVEL)
          begin
            next_state.ffull_flag = 1'b0;
          end
          if (state.drdy_flag)
          begin
            next_state.drdy_flag = 1'b0;
            next_state.drdy_live = 1'b0;
          end
        end
        default: next_state.rdata = 8'h00;
      endcase
    end

    // Non-latched flags follow their conditions; events always win over clears.
    if (!latch)
    begin
      next_state.fwtm_flag = wtm_hit;
    end
    else if (wtm_hit && !state.wtm_cond)
    begin
      next_state.fwtm_flag = 1'b1;
    end
    if (fifo_fill >= seiu_pkg::FIFO_FULL_LEVEL)
    begin
      next_state.ffull_flag = 1'b1;
    end
    else if (!latch)
    begin
      next_state.ffull_flag = 1'b0;
    end

    // Self-clear countdown for non-latched data-ready.
    if (state.drdy_us != 12'h000 && state.us_tick)
    begin
      next_state.drdy_us = state.drdy_us - 1'b1;
      if (state.drdy_us == 12'h001)
      begin
        next_state.drdy_live = 1'b0;
        if (!latch)
        begin
          next_state.drdy_flag = 1'b0;
        end
      end
    end
    if (conv_done)
    begin
      next_state.drdy_flag = 1'b1;
      next_state.drdy_live = 1'b1;
      next_state.drdy_us = latch ? 12'h000 : 12'(seiu_pkg::DRDY_CLR_US);
      next_state.press_data = press_raw;
      next_state.temp_data = temp_raw;
    end

    // Pad drive: open-drain releases the pad whenever it would drive it high.
    next_state.pad_out = state.ctrl[seiu_pkg::CTRL_LEVEL] ? pad_active : !pad_active;
    if (state.ctrl[seiu_pkg::CTRL_DRIVE])
    begin
      next_state.pad_oe_n = state.ctrl[seiu_pkg::CTRL_LEVEL] ? pad_active : !pad_active;
    end
    else
    begin
      next_state.pad_oe_n = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= '0;
      state.ctrl <= seiu_pkg::CTRL_RESET;
      state.wtm_low <= seiu_pkg::WTM_RESET[7:0];
      state.wtm_high <= {7'h00, seiu_pkg::WTM_RESET[8]};
      state.wtm_level <= seiu_pkg::WTM_RESET;
      state.pad_oe_n <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign press_data = state.press_data;
  assign temp_data = state.temp_data;
  assign pad_out = state.pad_out;
  assign pad_oe_n = state.pad_oe_n;
endmodule // seiu_event_unit

/* rtl/seiu_pkg.sv */
package seiu_pkg;
  // Clock rate and derived microsecond tick.
  localparam int CLK_HZ = 20000000;
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 5;
  // Data-ready self-clear time in microseconds (2.5 ms).
  localparam int DRDY_CLR_US = 2500;
  // Conversion time terms in microseconds.
  localparam int CONV_BASE_US = 234;
  localparam int CONV_PRESS_US = 392;
  localparam int CONV_TEMP_US = 163;
  localparam int CONV_OSR_US = 2020;
  localparam int US_W = 18;
  // Output rate ceiling.
  localparam int ODR_BASE_HZ = 200;
  localparam int ODR_BASE_US = 1000000 / ODR_BASE_HZ;
  // FIFO full threshold in bytes.
  localparam logic [9:0] FIFO_FULL_LEVEL = 10'h1f8;
  // Register offsets of the serial interface.
  localparam logic [7:0] WTM_LOW_ADDR = 8'h15;
  localparam logic [7:0] WTM_HIGH_ADDR = 8'h16;
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h11;
  localparam logic [7:0] EVT_CTRL_ADDR = 8'h19;
  // Control register field positions.
  localparam int CTRL_DRIVE = 0;
  localparam int CTRL_LEVEL = 1;
  localparam int CTRL_LATCH = 2;
  localparam int CTRL_FWTM_EN = 3;
  localparam int CTRL_FFULL_EN = 4;
  localparam int CTRL_DRDY_EN = 6;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  // Status register field positions.
  localparam int STAT_FWTM = 0;
  localparam int STAT_FFULL = 1;
  localparam int STAT_DRDY = 3;
  localparam logic [8:0] WTM_RESET = 9'h001;
endpackage
